// File: src/ipc_pkg.sv
// package: constants, register map and types of the interrupt priority controller
package ipc_pkg;
  // ==========================================
  // sizes
  localparam int IPC_NSRC = 11;   // request sources
  localparam int IPC_NGRP = 7;    // shared vectors / priority levels
  localparam int IPC_NLINE = 6;   // edge lines: five pins plus stop release
  localparam int IPC_AW = 10;     // nibble address width
  localparam int IPC_VW = 14;     // program address width
  localparam int IPC_SYNC = 2;    // synchroniser stages

  // ==========================================
  // nibble offsets of the control bits
  localparam logic [IPC_AW-1:0] OFS_CTRL0 = 10'h000;
  localparam logic [IPC_AW-1:0] OFS_CTRL1 = 10'h001;
  localparam logic [IPC_AW-1:0] OFS_TBC = 10'h002;
  localparam logic [IPC_AW-1:0] OFS_TDS1 = 10'h003;
  localparam logic [IPC_AW-1:0] OFS_EXT23 = 10'h022;
  localparam logic [IPC_AW-1:0] OFS_EXT4S2 = 10'h023;
  localparam logic [IPC_AW-1:0] OFS_EDGE_SELECT_FIRST = 10'h026;
  localparam logic [IPC_AW-1:0] OFS_EDGE_SELECT_SECOND = 10'h027;

  // ==========================================
  // field positions
  localparam logic [1:0] BIT_IE = 2'h0;  // global enable in nibble 0
  // source order: ext0, ext1, timer a, timer b, ext2, timer c, ext3, timer d, ext4, serial1, serial2
  localparam logic [IPC_AW-1:0] FLAG_OFS [IPC_NSRC] = '{OFS_CTRL0, OFS_CTRL1, OFS_CTRL1, OFS_TBC,
    OFS_EXT23, OFS_TBC, OFS_EXT23, OFS_TDS1, OFS_EXT4S2, OFS_TDS1, OFS_EXT4S2};
  // flag bit; the mask always sits one bit above its flag
  localparam logic [1:0] FLAG_BIT [IPC_NSRC] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h0, 2'h2, 2'h2, 2'h0,
    2'h0, 2'h2, 2'h2};
  localparam logic [2:0] SRC_GRP [IPC_NSRC] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5,
    3'h5, 3'h6, 3'h6};
  // edge select fields: two bits per line, line 2 and 3 in the first register, line 4 in the second
  localparam int ESR_LINE2_POS = 0;
  localparam int ESR_LINE3_POS = 2;
  localparam int ESR_LINE4_POS = 0;

  // ==========================================
  // vectors, highest priority first
  localparam logic [IPC_VW-1:0] RESET_VEC = 14'h0000;
  localparam logic [IPC_VW-1:0] VEC_ADDR [IPC_NGRP] = '{14'h0002, 14'h0004, 14'h0006, 14'h0008,
    14'h000A, 14'h000C, 14'h000E};

  // ==========================================
  // reset values
  localparam logic IE_RST = 1'b0;
  localparam logic FLAG_RST = 1'b0;
  localparam logic MASK_RST = 1'b1;
  localparam logic [3:0] ESR_RST = 4'h0;
  localparam logic PIN_IDLE = 1'b1;  // pins idle high

  // ==========================================
  // edge select encoding
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // acknowledge sequence
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_FIN = 4'b0010,
    S_PUSH = 4'b0100,
    S_FETCH = 4'b1000
  } ipc_state_t;
endpackage

// File: src/ipc_edge_if.sv
// interface: raw lines, edge selects and detected edge pulses
`timescale 1ns/1ps
interface ipc_edge_if;
  import ipc_pkg::*;
  logic [IPC_NLINE-1:0] pin;      // raw line levels
  logic [2*IPC_NLINE-1:0] sel;    // two-bit edge select per line
  logic [IPC_NLINE-1:0] pulse;    // one-cycle edge pulse per line
  modport det (input pin, input sel, output pulse);
  modport ctl (output pin, output sel, input pulse);
endinterface

// File: src/ipc_edge_det.sv
// module: synchronisers and selectable edge detection for the external lines
`timescale 1ns/1ps
module ipc_edge_det
  import ipc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  ipc_edge_if.det e
);
  // ==========================================
  // per line: two-stage synchroniser, then a history flop
  for (genvar i = 0; i < IPC_NLINE; i++) begin : g_line
    logic s1;    // first stage, read by s2 only
    logic s2;    // settled level
    logic prev;  // level one cycle earlier
    // synchronise before edge detection so each edge is seen once
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        s1 <= PIN_IDLE;
        s2 <= PIN_IDLE;
        prev <= PIN_IDLE;
      end else begin
        s1 <= e.pin[i];
        s2 <= s1;
        prev <= s2;
      end
    end
    // exactly one pulse per qualifying edge
    assign e.pulse[i] = (e.sel[2*i] & prev & ~s2) | (e.sel[2*i+1] & ~prev & s2);

    // a pulse always follows a real change of the settled level
    edge_once_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      e.pulse[i] |-> (s2 != prev) ##1 !e.pulse[i]) else $error("edge pulse without change");
  end
endmodule

// File: src/ipc_top.sv
// module: interrupt priority controller with nibble bit access and acknowledge sequence
//
// Operation
// - eleven sources: five pins, four timers, two serial
// - software can clear flags, never set them
// - reset: enable and flags zero, masks one
// - request is flag one, mask zero, enabled
// - ack: finish, clear enable, push, fetch vector
// - seven fixed priorities with vectors 0x02 to 0x0E
// - stop release vectors zero, only in stop
// - highest active group wins, lower ones keep waiting
// - enable at nibble zero bit zero, ack/return
// - lines zero and one set on falling edge
// - lines two to four use edge selects
// - mask zero passes, mask one blocks
// - timer a flag bit 2, mask bit 3
// - nibble two holds timers b and c
// - timer d flag by overflow or capture
// - serial flags on transfer end or suspend
// - control bits in reserved nibbles, bit access
// - request waits while enable is zero
`timescale 1ns/1ps
module ipc_top
  import ipc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ext_irq_pin0,
  input wire logic ext_irq_pin1,
  input wire logic ext_irq_pin2,
  input wire logic ext_irq_pin3,
  input wire logic ext_irq_pin4,
  input wire logic stop_release_pin,
  input wire logic stop_mode,
  input wire logic timer_a_ovf,
  input wire logic timer_b_ovf,
  input wire logic timer_c_ovf,
  input wire logic timer_d_ovf,
  input wire logic capture_enable,
  input wire logic capture_event_d,
  input wire logic serial1_done,
  input wire logic serial2_done,
  input wire logic [IPC_AW-1:0] ram_addr,
  input wire logic [1:0] ram_bit,
  input wire logic ram_nib_wr,
  input wire logic [3:0] ram_wdata,
  input wire logic ram_bit_set,
  input wire logic ram_bit_clr,
  input wire logic ram_rd,
  input wire logic return_from_handler_op,
  output logic [3:0] ram_rdata,
  output logic ram_hit,
  output logic seq_finish,
  output logic seq_push,
  output logic seq_fetch,
  output logic [IPC_VW-1:0] vector_addr,
  output logic stop_release_req,
  output logic global_irq_enable
);
  // ==========================================
  // state
  logic [IPC_NSRC-1:0] flag;      // request flags
  logic [IPC_NSRC-1:0] mask;      // request masks
  logic [3:0] edge_select_first;  // edge selects for lines 2 and 3
  logic [3:0] edge_select_second; // edge select for line 4
  ipc_state_t state;              // acknowledge sequence
  logic [IPC_NSRC-1:0] evt;       // hardware set pulses
  logic [IPC_NGRP-1:0] grp_req;   // unmasked pending term per group
  logic [IPC_VW-1:0] win_vec;     // vector of the winning group
  logic [3:0] we;                 // per-bit write enable
  logic [3:0] wv;                 // per-bit written value
  logic [3:0] rd_nib;             // read nibble
  logic rd_hit;                   // address belongs to this block

  // ==========================================
  // edge detection on the pins
  ipc_edge_if eif ();
  assign eif.pin = {stop_release_pin, ext_irq_pin4, ext_irq_pin3, ext_irq_pin2, ext_irq_pin1,
    ext_irq_pin0};
  // lines 0, 1 and stop release are fixed falling; 2 to 4 follow the selects
  assign eif.sel = {EDGE_FALL, edge_select_second[ESR_LINE4_POS +: 2],
    edge_select_first[ESR_LINE3_POS +: 2], edge_select_first[ESR_LINE2_POS +: 2],
    EDGE_FALL, EDGE_FALL};
  ipc_edge_det u_edge (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .e(eif.det)
  );

  // event vector in source order
  assign evt = {serial2_done, serial1_done, eif.pulse[4],
    timer_d_ovf | (capture_enable & capture_event_d),
    eif.pulse[3], timer_c_ovf, eif.pulse[2], timer_b_ovf,
    timer_a_ovf, eif.pulse[1], eif.pulse[0]};

  // ==========================================
  // bit access decode: a nibble write touches all four bits, a bit op one bit
  always_comb begin
    we = 4'h0;
    wv = 4'h0;
    if (ram_nib_wr) begin
      we = 4'hF;
      wv = ram_wdata;
    end else if (ram_bit_set | ram_bit_clr) begin
      we[ram_bit] = 1'b1;
      wv[ram_bit] = ram_bit_set;
    end
  end

  // ==========================================
  // flags and masks, one slice per source
  for (genvar i = 0; i < IPC_NSRC; i++) begin : g_src
    localparam logic [1:0] MB = FLAG_BIT[i] + 2'h1;  // mask bit
    logic hit;
    assign hit = (ram_addr == FLAG_OFS[i]);
    // flag: hardware sets, software may only clear; set wins
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        flag[i] <= FLAG_RST;
      end else if (evt[i]) begin
        flag[i] <= 1'b1;
      end else if (hit & we[FLAG_BIT[i]] & ~wv[FLAG_BIT[i]]) begin
        flag[i] <= 1'b0;
      end
    end
    // mask: plain read/write bit
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        mask[i] <= MASK_RST;
      end else if (hit & we[MB]) begin
        mask[i] <= wv[MB];
      end
    end
  end

  // ==========================================
  // edge select registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      edge_select_first <= ESR_RST;
      edge_select_second <= ESR_RST;
    end else begin
      // bit ops mix the old value with the touched bit
      if (ram_addr == OFS_EDGE_SELECT_FIRST) begin
        edge_select_first <= (edge_select_first & ~we) | (wv & we);
      end
      if (ram_addr == OFS_EDGE_SELECT_SECOND) begin
        edge_select_second <= (edge_select_second & ~we) | (wv & we);
      end
    end
  end

  // ==========================================
  // global enable: ack clears in cycle two, return sets, software may write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      global_irq_enable <= IE_RST;
    end else if (state == S_FIN) begin
      // cleared on entry to cycle two; beats any concurrent set
      global_irq_enable <= 1'b0;
    end else if (return_from_handler_op) begin
      global_irq_enable <= 1'b1;
    end else if (ram_addr == OFS_CTRL0 && we[BIT_IE]) begin
      global_irq_enable <= wv[BIT_IE];
    end
  end

  // ==========================================
  // group terms and fixed priority
  always_comb begin
    grp_req = '0;
    for (int i = 0; i < IPC_NSRC; i++) begin
      if (flag[i] & ~mask[i]) begin
        grp_req[SRC_GRP[i]] = 1'b1;
      end
    end
  end
  // scan low to high priority so the highest active group is written last
  always_comb begin
    win_vec = VEC_ADDR[0];
    for (int g = IPC_NGRP - 1; g >= 0; g--) begin
      if (grp_req[g]) begin
        win_vec = VEC_ADDR[g];
      end
    end
  end

  // ==========================================
  // acknowledge sequence; pending terms simply wait in the flags
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
    end else begin
      unique case (state)
        S_IDLE: begin
          // taken only with the enable set
          if (global_irq_enable && |grp_req) begin
            state <= S_FIN;
          end
        end
        S_FIN: begin
          state <= S_PUSH;
        end
        S_PUSH: begin
          state <= S_FETCH;
        end
        S_FETCH: begin
          state <= S_IDLE;
        end
      endcase
    end
  end
  assign seq_finish = state[1];
  assign seq_fetch = state[3];
  // push strobe gets its own flop so the output never comes from an or gate;
  // it covers cycles two and three of the acknowledge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      seq_push <= 1'b0;
    end else begin
      seq_push <= (state == S_FIN) || (state == S_PUSH);
    end
  end

  // ==========================================
  // vector and stop release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vector_addr <= RESET_VEC;
      stop_release_req <= 1'b0;
    end else begin
      // stop release only counts while stopped
      stop_release_req <= stop_mode & eif.pulse[5];
      if (stop_mode & eif.pulse[5]) begin
        vector_addr <= RESET_VEC;
      end else if (state == S_IDLE && global_irq_enable && |grp_req) begin
        // latched at acceptance so later flags cannot move it mid-sequence
        vector_addr <= win_vec;
      end
    end
  end

  // ==========================================
  // read path, registered
  always_comb begin
    rd_nib = 4'h0;
    rd_hit = (ram_addr == OFS_EDGE_SELECT_FIRST) || (ram_addr == OFS_EDGE_SELECT_SECOND);
    if (ram_addr == OFS_CTRL0) begin
      rd_nib[BIT_IE] = global_irq_enable;
    end
    if (ram_addr == OFS_EDGE_SELECT_FIRST) begin
      rd_nib = edge_select_first;
    end
    if (ram_addr == OFS_EDGE_SELECT_SECOND) begin
      rd_nib = edge_select_second;
    end
    for (int i = 0; i < IPC_NSRC; i++) begin
      if (ram_addr == FLAG_OFS[i]) begin
        rd_hit = 1'b1;
        rd_nib[FLAG_BIT[i]] = flag[i];
        rd_nib[FLAG_BIT[i] + 2'h1] = mask[i];
      end
    end
  end
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ram_rdata <= 4'h0;
      ram_hit <= 1'b0;
    end else begin
      ram_hit <= ram_rd & rd_hit;
      if (ram_rd) begin
        ram_rdata <= rd_nib;
      end
    end
  end

  // ==========================================
  // checks
  logic first_cyc;  // high in the first cycle after reset release
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      first_cyc <= 1'b1;
    end else begin
      first_cyc <= 1'b0;
    end
  end

  reset_vals_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    first_cyc |-> (!global_irq_enable && flag == '0 && mask == '1)) else $error("bad reset values");
  no_sw_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (flag & ~$past(flag) & ~$past(evt)) == '0) else $error("flag set without event");
  set_wins_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ($past(evt) & ~flag) == '0) else $error("event lost");
  take_req_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == S_IDLE && global_irq_enable && |grp_req) |=> seq_finish) else $error("request not taken");
  hold_off_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == S_IDLE && !global_irq_enable) |=> !seq_finish) else $error("taken while disabled");
  masked_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state == S_IDLE && mask == '1) |=> !seq_finish) else $error("masked source taken");
  ack_seq_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(seq_finish) |-> ##1 (seq_push && !seq_fetch) ##1 seq_fetch ##1 !seq_push)
    else $error("bad acknowledge sequence");
  ie_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (seq_push && !seq_fetch) |-> !global_irq_enable) else $error("enable not cleared");
  ie_return_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (return_from_handler_op && state != S_FIN) |=> global_irq_enable) else $error("return did not enable");
  prio_vec_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(seq_finish) && !$past(stop_mode & eif.pulse[5]) |-> vector_addr == $past(win_vec))
    else $error("wrong vector latched");
  top_prio_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    grp_req[0] |-> win_vec == VEC_ADDR[0]) else $error("top group not chosen");
  stop_only_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    stop_release_req |-> $past(stop_mode) && vector_addr == RESET_VEC) else $error("stop release outside stop");
  // stop release is dropped whenever the device is running
  stop_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    !stop_mode |=> !stop_release_req) else $error("release outside stop");
  // a read of a foreign nibble must stay silent so other ram answers alone
  unmapped_rd_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ram_rd && !rd_hit) |=> (!ram_hit && ram_rdata == 4'h0)) else $error("unmapped read answered");
  // the registered read returns the nibble seen at the request edge
  rd_data_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    ram_rd |=> ram_rdata == $past(rd_nib)) else $error("read data wrong");
  // a software clear with no event drops the flag
  sw_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ram_addr == OFS_CTRL0 && we[2] && !wv[2] && !evt[0]) |=> !flag[0]) else $error("flag not cleared");
  // a software write of the enable lands unless the ack or a return overrides it
  ie_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state != S_FIN && !return_from_handler_op && ram_addr == OFS_CTRL0 && we[BIT_IE])
    |=> global_irq_enable == $past(wv[BIT_IE])) else $error("enable write lost");
  // a whole-nibble write replaces the edge selects
  esr_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (ram_addr == OFS_EDGE_SELECT_FIRST && ram_nib_wr) |=> edge_select_first == $past(ram_wdata))
    else $error("edge select write lost");

  ack_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(seq_finish) ##3 !seq_push);
  stop_seen_c: cover property (@(posedge ref_clk) disable iff (!nrst) stop_release_req);
  clash_c: cover property (@(posedge ref_clk) disable iff (!nrst) evt[7] && ram_addr == OFS_TDS1 && we[0]);
  shared_c: cover property (@(posedge ref_clk) disable iff (!nrst) flag[3] && flag[4] && seq_finish);
endmodule

// File: sim/ipc_cpu_model.sv
// cpu sequencer model: records fetched vectors and returns from handlers
`timescale 1ns/1ps
module ipc_cpu_model
  import ipc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic seq_fetch,
  input wire logic [IPC_VW-1:0] vector_addr,
  input wire logic [7:0] ret_delay,
  output logic return_from_handler_op,
  output logic [IPC_VW-1:0] last_vec
);
  // ==========================================
  // handler model
  // the handler body lasts ret_delay cycles so the bench can clear the flag first
  initial begin
    return_from_handler_op = 1'b0;
    last_vec = 14'h0000;
    forever begin
      @(posedge ref_clk);
      #1;
      // fetch cycle: remember where the core jumped
      if (nrst === 1'b1 && seq_fetch === 1'b1) begin
        last_vec = vector_addr;
        repeat (ret_delay) @(posedge ref_clk);
        #1;
        return_from_handler_op = 1'b1;
        @(posedge ref_clk);
        #1;
        return_from_handler_op = 1'b0;
      end
    end
  end
endmodule

// File: sim/ipc_top_tb.sv
// testbench of the interrupt priority controller
`timescale 1ns/1ps
module ipc_top_tb;
  import ipc_pkg::*;
  // ==========================================
  // stimulus and observed signals
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [4:0] pin = 5'h1F; // external lines idle high
  logic stop_release_pin = 1'b1;
  logic stop_mode = 1'b0;
  logic [3:0] ovf = 4'h0; // timer a..d overflow pulses
  logic capture_enable = 1'b1;
  logic capture_event_d = 1'b0;
  logic [1:0] sdone = 2'h0; // serial 1 and 2 done pulses
  logic [IPC_AW-1:0] ram_addr = 10'h000;
  logic [1:0] ram_bit = 2'h0;
  logic ram_nib_wr = 1'b0;
  logic [3:0] ram_wdata = 4'h0;
  logic ram_bit_set = 1'b0;
  logic ram_bit_clr = 1'b0;
  logic ram_rd = 1'b0;
  logic [7:0] ret_delay = 8'h0C; // handler length in cycles
  logic ret_op, ram_hit, seq_finish, seq_push, seq_fetch, stop_req, g_en;
  logic [3:0] ram_rdata;
  logic [IPC_VW-1:0] vector_addr, last_vec;
  int miscompares = 0;
  int n_compared = 0;
  int n_ack = 0; // acknowledge sequences seen
  int n_stop = 0; // stop release pulses seen
  // expected vector per source, in package source order
  localparam logic [13:0] EXP_VEC [11] = '{14'h0002, 14'h0004, 14'h0006, 14'h0008, 14'h0008,
    14'h000A, 14'h000A, 14'h000C, 14'h000C, 14'h000E, 14'h000E};
  always #25 ref_clk = ~ref_clk;
  // count pulses on the falling edge where outputs are settled
  always @(negedge ref_clk) begin
    if (seq_finish === 1'b1) n_ack++;
    if (stop_req === 1'b1) n_stop++;
  end
  ipc_top uut (.ref_clk(ref_clk), .nrst(nrst), .ext_irq_pin0(pin[0]), .ext_irq_pin1(pin[1]),
    .ext_irq_pin2(pin[2]), .ext_irq_pin3(pin[3]), .ext_irq_pin4(pin[4]),
    .stop_release_pin(stop_release_pin), .stop_mode(stop_mode), .timer_a_ovf(ovf[0]),
    .timer_b_ovf(ovf[1]), .timer_c_ovf(ovf[2]), .timer_d_ovf(ovf[3]),
    .capture_enable(capture_enable), .capture_event_d(capture_event_d),
    .serial1_done(sdone[0]), .serial2_done(sdone[1]), .ram_addr(ram_addr), .ram_bit(ram_bit),
    .ram_nib_wr(ram_nib_wr), .ram_wdata(ram_wdata), .ram_bit_set(ram_bit_set),
    .ram_bit_clr(ram_bit_clr), .ram_rd(ram_rd), .return_from_handler_op(ret_op),
    .ram_rdata(ram_rdata), .ram_hit(ram_hit), .seq_finish(seq_finish), .seq_push(seq_push),
    .seq_fetch(seq_fetch), .vector_addr(vector_addr), .stop_release_req(stop_req),
    .global_irq_enable(g_en));
  ipc_cpu_model cpu (.ref_clk(ref_clk), .nrst(nrst), .seq_fetch(seq_fetch),
    .vector_addr(vector_addr), .ret_delay(ret_delay), .return_from_handler_op(ret_op),
    .last_vec(last_vec));
  // ==========================================
  // compare and report
  task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // nibble bus tasks, all drive 1 ns after the edge
  task automatic bit_op(input logic [IPC_AW-1:0] a, input logic [1:0] b, input logic v);
    @(posedge ref_clk);
    #1;
    ram_addr = a;
    ram_bit = b;
    ram_bit_set = v;
    ram_bit_clr = ~v;
    @(posedge ref_clk);
    #1;
    ram_bit_set = 1'b0;
    ram_bit_clr = 1'b0;
  endtask
  task automatic nib_wr(input logic [IPC_AW-1:0] a, input logic [3:0] d);
    @(posedge ref_clk);
    #1;
    ram_addr = a;
    ram_wdata = d;
    ram_nib_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    ram_nib_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [IPC_AW-1:0] a, input logic [3:0] exp, input logic hit);
    @(posedge ref_clk);
    #1;
    ram_addr = a;
    ram_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    ram_rd = 1'b0;
    chk_val("rdata", {12'h000, exp}, {12'h000, ram_rdata});
    chk_val("hit", {15'h0000, hit}, {15'h0000, ram_hit});
  endtask
  // ==========================================
  // acknowledge and return
  // waits for finish, then checks the push and fetch cycles one by one
  task automatic wait_ack(input logic [IPC_VW-1:0] vec);
    for (int n = 0; n < 30 && seq_finish !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk_val("ack finish", 16'h0001, {15'h0000, seq_finish});
    if (seq_finish !== 1'b1) print_verdict();
    chk_val("vector", {2'b00, vec}, {2'b00, vector_addr});
    @(posedge ref_clk);
    #1;
    chk_val("push, enable", 16'h0002, {14'h0000, seq_push, g_en});
    @(posedge ref_clk);
    #1;
    chk_val("push, fetch", 16'h0003, {14'h0000, seq_push, seq_fetch});
    @(posedge ref_clk);
    #1;
    chk_val("sequence end", 16'h0000, {13'h0000, seq_finish, seq_push, seq_fetch});
  endtask
  task automatic wait_ret(input logic [IPC_VW-1:0] vec);
    for (int n = 0; n < 40 && g_en !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk_val("enable after return", 16'h0001, {15'h0000, g_en});
    if (g_en !== 1'b1) print_verdict();
    chk_val("fetched vector", {2'b00, vec}, {2'b00, last_vec});
  endtask
  // ==========================================
  // scenarios
  task automatic reset_check;
    rd_chk(OFS_CTRL0, 4'h8, 1'b1);
    for (int k = 0; k < 5; k++) begin
      rd_chk(FLAG_OFS[2 * k + 1], 4'hA, 1'b1);
    end
    rd_chk(OFS_EDGE_SELECT_FIRST, 4'h0, 1'b1);
    nib_wr(10'h010, 4'hF);
    rd_chk(10'h010, 4'h0, 1'b0);
    nib_wr(OFS_CTRL1, 4'hF);
    rd_chk(OFS_CTRL1, 4'hA, 1'b1);
    bit_op(OFS_CTRL1, 2'd2, 1'b1);
    bit_op(OFS_CTRL0, 2'd1, 1'b1);
    rd_chk(OFS_CTRL1, 4'hA, 1'b1);
    rd_chk(OFS_CTRL0, 4'h8, 1'b1);
  endtask
  // raise source i: pins fall, others pulse one cycle
  task automatic fire(input int i);
    @(posedge ref_clk);
    #1;
    case (i)
      0, 1: pin[i] = 1'b0;
      2: ovf[0] = 1'b1;
      3: ovf[1] = 1'b1;
      4: pin[2] = 1'b0;
      5: ovf[2] = 1'b1;
      6: pin[3] = 1'b0;
      7: capture_event_d = 1'b1;
      8: pin[4] = 1'b0;
      default: sdone[i - 9] = 1'b1;
    endcase
    @(posedge ref_clk);
    #1;
    ovf = 4'h0;
    capture_event_d = 1'b0;
    sdone = 2'h0;
  endtask
  // one full service of source i, handler clears its flag and masks again
  task automatic serve(input int i);
    logic [IPC_AW-1:0] a;
    logic [1:0] b;
    logic [3:0] e;
    a = FLAG_OFS[i];
    b = FLAG_BIT[i];
    e = (a == OFS_CTRL0) ? 4'h8 : 4'hA;
    e[b + 1] = 1'b0;
    e[b] = 1'b1;
    bit_op(a, b + 2'd1, 1'b0);
    bit_op(OFS_CTRL0, BIT_IE, 1'b1);
    fire(i);
    wait_ack(EXP_VEC[i]);
    pin = 5'h1F;
    rd_chk(a, e, 1'b1);
    bit_op(a, b, 1'b0);
    bit_op(a, b + 2'd1, 1'b1);
    wait_ret(EXP_VEC[i]);
  endtask
  // two pending sources under a disabled enable, slow handler
  task automatic prio_check;
    ret_delay = 8'h1E;
    bit_op(OFS_CTRL0, BIT_IE, 1'b0);
    bit_op(OFS_CTRL1, 2'd3, 1'b0);
    bit_op(OFS_TDS1, 2'd3, 1'b0);
    fire(9);
    fire(2);
    repeat (6) @(posedge ref_clk);
    rd_chk(OFS_CTRL1, 4'h6, 1'b1);
    bit_op(OFS_CTRL0, BIT_IE, 1'b1);
    wait_ack(14'h0006);
    bit_op(OFS_CTRL1, 2'd2, 1'b0);
    wait_ret(14'h0006);
    wait_ack(14'h000E);
    bit_op(OFS_TDS1, 2'd2, 1'b0);
    bit_op(OFS_CTRL1, 2'd3, 1'b1);
    bit_op(OFS_TDS1, 2'd3, 1'b1);
    wait_ret(14'h000E);
  endtask
  // masked flag never starts a sequence; set beats a same-cycle clear
  task automatic mask_race;
    int a0;
    a0 = n_ack;
    fire(5);
    repeat (8) @(posedge ref_clk);
    chk_val("masked acks", 16'(a0), 16'(n_ack));
    rd_chk(OFS_TBC, 4'hE, 1'b1);
    bit_op(OFS_TBC, 2'd2, 1'b0);
    @(posedge ref_clk);
    #1;
    ovf[3] = 1'b1;
    ram_addr = OFS_TDS1;
    ram_bit = 2'd0;
    ram_bit_clr = 1'b1;
    @(posedge ref_clk);
    #1;
    ovf = 4'h0;
    ram_bit_clr = 1'b0;
    rd_chk(OFS_TDS1, 4'hB, 1'b1);
    bit_op(OFS_TDS1, 2'd0, 1'b0);
    rd_chk(OFS_TDS1, 4'hA, 1'b1);
  endtask
  // line 2 on rising edge only, one edge sets the flag once
  task automatic edge_check;
    nib_wr(OFS_EDGE_SELECT_FIRST, 4'h2);
    rd_chk(OFS_EDGE_SELECT_FIRST, 4'h2, 1'b1);
    pin[3:2] = 2'b00;
    repeat (5) @(posedge ref_clk);
    rd_chk(OFS_EXT23, 4'hA, 1'b1);
    pin[3:2] = 2'b11;
    repeat (5) @(posedge ref_clk);
    rd_chk(OFS_EXT23, 4'hB, 1'b1);
    bit_op(OFS_EXT23, 2'd0, 1'b0);
    rd_chk(OFS_EXT23, 4'hA, 1'b1);
    nib_wr(OFS_EDGE_SELECT_SECOND, 4'h3);
    pin[4] = 1'b0;
    repeat (5) @(posedge ref_clk);
    rd_chk(OFS_EXT4S2, 4'hB, 1'b1);
    bit_op(OFS_EXT4S2, 2'd0, 1'b0);
    pin[4] = 1'b1;
    repeat (5) @(posedge ref_clk);
    rd_chk(OFS_EXT4S2, 4'hB, 1'b1);
    bit_op(OFS_EXT4S2, 2'd0, 1'b0);
  endtask
  // stop release honoured only in stop mode
  task automatic stop_check;
    int s0;
    s0 = n_stop;
    stop_release_pin = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    stop_release_pin = 1'b1;
    stop_mode = 1'b1;
    repeat (4) @(posedge ref_clk);
    chk_val("stop ignored", 16'(s0), 16'(n_stop));
    #1;
    stop_release_pin = 1'b0;
    for (int n = 0; n < 10 && n_stop == s0; n++) @(posedge ref_clk);
    chk_val("stop honoured", 16'(s0 + 1), 16'(n_stop));
    chk_val("stop vector", {2'b00, RESET_VEC}, {2'b00, vector_addr});
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    nrst = 1'b1;
    reset_check();
    nib_wr(OFS_EDGE_SELECT_FIRST, 4'h5);
    nib_wr(OFS_EDGE_SELECT_SECOND, 4'h1);
    for (int i = 0; i < IPC_NSRC; i++) begin
      serve(i);
    end
    prio_check();
    mask_race();
    edge_check();
    stop_check();
    print_verdict();
  end
endmodule
